// file: logic/rapu_top.sv
`timescale 1ns/100ps
// Functional notes
// - Six regions: system, flash zero-three, SRAM four.
// - Permissions are hardwired, software cannot change.
// - Violation raises interrupt and sets cause bit.
// - Programmable bounds from registers, others from option word or fixed.
// - System below 0xC8; region zero starts 0xC8.
// - System code may access only region four of the numbered regions.
// - Region four is SRAM 0x1000_0000-0x1000_2000.
// - Region three ends at the option debug boundary, below 0x0002_0000.
// - Flash regions contiguous, end equals next start.
// - Checking only while control bit zero set.
// - Lower numbered region may read/write higher regions.
// - Higher never writes lower; reads one below.
// - Option zero: regions zero-two, option ends.
// - Option one: regions zero-three, option ends.
// - Option word bits 17:9 debug, 8:0 end.
// - Region zero end resets 0x1000, privileged write.
// - Region one end resets 0x2000, privileged write.
// - Unprivileged control writes abort; monitor always writable. Code aborts them only while control bit zero is set.
// - One interrupt line, one monitor bit per cause.
// - Write one level down aborts, read passes.
// - Two levels down or system-to-flash: downward abort.
module rapu_top (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // Option word sampled once after reset
    input  wire logic [31:0] option_word,
    // Core access being checked
    input  wire logic        acc_valid,
    input  wire logic [31:0] acc_addr,
    input  wire logic        acc_write,
    input  wire logic [31:0] exec_addr,
    output logic             acc_abort,
    output logic [31:0]      abort_addr,
    // APB slave for the protection registers
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Shared violation interrupt
    output logic             protection_violation_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic                       protection_control_reg;
    logic [31:0]                flash_r0_end_bound;
    logic [31:0]                flash_r1_end_bound;
    logic [31:0]                violation_monitor_word;
    logic [rapu_pkg::MON_W-1:0] violation_cause_monitor;
    logic [31:0]                opt_word;
    logic                       opt_loaded;

    ////////////////////////////////////////////////////////////////////////////
    // Option word decode

    logic        region_count_option;
    logic [31:0] debug_boundary_option;
    logic [31:0] region_boundary_option;

    // The option word is a strap that is taken once and never again, so a
    // later change on the pin moves no boundary until the next reset
    // Nine-bit fields count 256-byte pages of the flash
    assign region_count_option    = opt_word[rapu_pkg::OPT_SEL_BIT];
    assign debug_boundary_option  = {15'h0000,
        opt_word[rapu_pkg::OPT_DBG_HI:rapu_pkg::OPT_DBG_LO], 8'h00};
    assign region_boundary_option = {15'h0000,
        opt_word[rapu_pkg::OPT_END_HI:rapu_pkg::OPT_END_LO], 8'h00};

    ////////////////////////////////////////////////////////////////////////////
    // Region bounds

    logic [31:0] flash_r1_start_bound;
    logic [31:0] flash_r2_start_bound;
    logic [31:0] flash_r3_start_bound;
    logic [31:0] flash_r2_end_bound;
    logic [31:0] r1_end_eff;
    logic [31:0] top_end;

    // In the three-region option the end register is kept but unused
    // so software may write it without moving any boundary
    // Each start is the previous end, so no gap can open between regions
    assign flash_r1_start_bound = flash_r0_end_bound;
    assign r1_end_eff           = region_count_option ? flash_r1_end_bound
                                                      : region_boundary_option;
    assign flash_r2_start_bound = r1_end_eff;
    assign flash_r2_end_bound   = region_count_option ? region_boundary_option
                                                      : debug_boundary_option;
    assign flash_r3_start_bound = flash_r2_end_bound;
    // Region three exists only in the four-region option
    assign top_end              = region_count_option ? debug_boundary_option
                                                      : flash_r2_end_bound;

    ////////////////////////////////////////////////////////////////////////////
    // Address classifier, shared by target and executing code
    // Flash tests follow the system test and only region three is capped at the
    // flash top, so a bound written past it takes over the fixed spaces above
    // it; the order of the tests carries the priority

    function automatic rapu_pkg::rapu_region_e classify(input logic [31:0] a,
                                                        input logic [31:0] e0,
                                                        input logic [31:0] e1,
                                                        input logic [31:0] e2,
                                                        input logic [31:0] e3,
                                                        input logic        four);
        rapu_pkg::rapu_region_e r;
        r = rapu_pkg::RG_INV;
        if (a < rapu_pkg::R0_START) begin
            r = rapu_pkg::RG_SYS;
        end else if (a < e0) begin
            r = rapu_pkg::RG_R0;
        end else if (a < e1) begin
            r = rapu_pkg::RG_R1;
        end else if (a < e2) begin
            r = rapu_pkg::RG_R2;
        end else if (four && a < e3 && a < rapu_pkg::FLASH_END) begin
            r = rapu_pkg::RG_R3;
        end else if (a >= rapu_pkg::SRAM_START && a < rapu_pkg::SRAM_END) begin
            r = rapu_pkg::RG_R4;
        end else if (a >= rapu_pkg::PSFR_START && a < rapu_pkg::PSFR_END) begin
            r = rapu_pkg::RG_PSFR;
        end else if (a >= rapu_pkg::SFR_START && a < rapu_pkg::SFR_END) begin
            r = rapu_pkg::RG_SFR;
        end else if (a >= rapu_pkg::PERI_START && a < rapu_pkg::PERI_END) begin
            r = rapu_pkg::RG_PERI;
        end
        return r;
    endfunction

    rapu_pkg::rapu_region_e tgt_rg;
    rapu_pkg::rapu_region_e src_rg;

    // Each region is bounded by the start of the next one
    assign tgt_rg = classify(acc_addr, flash_r1_start_bound, flash_r2_start_bound,
                             flash_r3_start_bound, top_end, region_count_option);
    assign src_rg = classify(exec_addr, flash_r1_start_bound, flash_r2_start_bound,
                             flash_r3_start_bound, top_end, region_count_option);

    ////////////////////////////////////////////////////////////////////////////
    // Permission matrix, fixed in logic and not reachable by software

    logic       src_is_sys;
    logic       src_is_num;
    logic       tgt_is_sys;
    logic       tgt_is_num;
    logic [3:0] src_lvl;
    logic [3:0] tgt_lvl;
    logic       privileged;
    logic       tgt_monitor;

    // Levels reuse the enum codes, R0 at 1 up to at 5, so a single add
    // tells a one-level step from a deeper one; no register can alter this
    assign src_is_sys  = (src_rg == rapu_pkg::RG_SYS);
    // Code running from outside the numbered regions and the system area is ranked as region four
    assign src_is_num  = !src_is_sys;
    assign tgt_is_sys  = (tgt_rg == rapu_pkg::RG_SYS);
    assign tgt_is_num  = (tgt_rg >= rapu_pkg::RG_R0) && (tgt_rg <= rapu_pkg::RG_R4);
    assign src_lvl     = (src_rg >= rapu_pkg::RG_R0 && src_rg <= rapu_pkg::RG_R4)
                         ? src_rg : rapu_pkg::RG_R4;
    assign tgt_lvl     = tgt_rg;
    assign privileged  = (src_rg == rapu_pkg::RG_R0) || (src_rg == rapu_pkg::RG_R1);
    assign tgt_monitor = (acc_addr[7:0] == rapu_pkg::OFS_MONITOR);

    // Causes are exclusive: one access sets at most one monitor bit
    logic cause_down;
    logic cause_adj;
    logic cause_sys;
    logic cause_ctrl;
    logic cause_inv;

    // System code may only use region four among the numbered regions
    assign cause_down = (src_is_sys && tgt_is_num && tgt_rg != rapu_pkg::RG_R4)
                     || (src_is_num && tgt_is_num && tgt_lvl + 4'h1 < src_lvl);
    // One level down: reads pass, writes abort
    assign cause_adj  = src_is_num && tgt_is_num && acc_write
                     && (tgt_lvl + 4'h1 == src_lvl);
    assign cause_sys  = src_is_num && tgt_is_sys && acc_write;
    assign cause_ctrl = (tgt_rg == rapu_pkg::RG_PSFR) && acc_write
                     && !privileged && !tgt_monitor;
    assign cause_inv  = (tgt_rg == rapu_pkg::RG_INV);

    // Lower to higher between numbered regions is never flagged by any term above
    logic [rapu_pkg::MON_W-1:0] acc_causes;
    logic                       acc_hit;

    assign acc_causes = {cause_inv, cause_sys, cause_down, cause_adj, cause_ctrl};
    // Checking only runs with protection enabled
    assign acc_hit    = acc_valid && protection_control_reg && (|acc_causes);

    ////////////////////////////////////////////////////////////////////////////
    // APB decode; the control side uses the region of the code now running

    logic        apb_setup;
    logic        apb_wr;
    logic        apb_rd;
    logic        sel_ctrl;
    logic        sel_r0;
    logic        sel_r1;
    logic        sel_opt;
    logic        sel_stat;
    logic        sel_mon;
    logic        sel_any;
    logic        ctrl_denied;
    logic        ctrl_wr_ok;
    logic        apb_ctrl_abort;
    logic [31:0] next_prdata;

    assign apb_setup      = psel && !penable;
    assign apb_wr         = psel && penable && pwrite;
    assign apb_rd         = psel && penable && !pwrite;
    assign sel_ctrl       = (paddr == rapu_pkg::OFS_CTRL);
    assign sel_r0         = (paddr == rapu_pkg::OFS_R0_END);
    assign sel_r1         = (paddr == rapu_pkg::OFS_R1_END);
    assign sel_opt        = (paddr == rapu_pkg::OFS_OPTION);
    assign sel_stat       = (paddr == rapu_pkg::OFS_STATUS);
    assign sel_mon        = (paddr == rapu_pkg::OFS_MONITOR);
    assign sel_any        = sel_ctrl | sel_r0 | sel_r1 | sel_opt | sel_stat | sel_mon;
    // A write from unprivileged code is refused only once protection is on;
    // before that the bounds stay writable for start-up code, which is the
    // price of letting boot code set up the map from anywhere
    // Bound registers follow the same privilege as the control bit
    assign ctrl_denied    = protection_control_reg && !privileged
                            && (sel_ctrl | sel_r0 | sel_r1);
    assign ctrl_wr_ok     = apb_wr && !ctrl_denied;
    assign apb_ctrl_abort = apb_wr && ctrl_denied;

    // Zero wait states; unmapped or denied writes answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel && penable && (!sel_any || apb_ctrl_abort);

    always_comb begin
        next_prdata = 32'h0000_0000;
        if (sel_ctrl) begin
            next_prdata[rapu_pkg::CTRL_EN_BIT] = protection_control_reg;
        end else if (sel_r0) begin
            next_prdata = flash_r0_end_bound;
        end else if (sel_r1) begin
            next_prdata = flash_r1_end_bound;
        end else if (sel_opt) begin
            next_prdata = opt_word;
        end else if (sel_stat) begin
            next_prdata = {28'h000_0000, src_rg};
        end else if (sel_mon) begin
            next_prdata = violation_monitor_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Option capture: taken one edge after reset release, never under reset
    // Until then the option bounds read as zero, so the core must hold off its
    // accesses until the second edge after release

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            opt_word   <= 32'h0000_0000;
            opt_loaded <= 1'b0;
        end else if (!opt_loaded) begin
            opt_word   <= option_word;
            opt_loaded <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control and bound registers
    // Bounds are taken as full words; software must keep them in rising order,
    // since nothing here checks that r0 end stays below end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            protection_control_reg <= 1'b0;
            flash_r0_end_bound     <= rapu_pkg::R0_END_RST;
            flash_r1_end_bound     <= rapu_pkg::R1_END_RST;
        end else if (ctrl_wr_ok) begin
            if (sel_ctrl) begin
                protection_control_reg <= pwdata[rapu_pkg::CTRL_EN_BIT];
            end
            if (sel_r0) begin
                flash_r0_end_bound <= pwdata;
            end
            if (sel_r1) begin
                flash_r1_end_bound <= pwdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Monitor: write one clears a cause, a new event in that cycle wins
    // Letting the set win means an abort that races a clear from the handler
    // is never lost; the handler simply sees the bit again

    logic [rapu_pkg::MON_W-1:0] set_causes;
    logic [rapu_pkg::MON_W-1:0] clr_causes;

    assign set_causes = (acc_hit ? acc_causes : {rapu_pkg::MON_W{1'b0}})
                      | {{(rapu_pkg::MON_W-1){1'b0}}, apb_ctrl_abort};
    assign clr_causes = (apb_wr && sel_mon) ? pwdata[rapu_pkg::MON_W-1:0]
                                            : {rapu_pkg::MON_W{1'b0}};

    assign violation_monitor_word = {{(32-rapu_pkg::MON_W){1'b0}}, violation_cause_monitor};

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            violation_cause_monitor <= {rapu_pkg::MON_W{1'b0}};
        end else begin
            violation_cause_monitor <= (violation_cause_monitor & ~clr_causes)
                                     | set_causes;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Abort answer and read data
    // Read data is loaded in the setup cycle so it stands through the access
    // cycle, and is zeroed when idle so no stale word lingers on the bus

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            acc_abort  <= 1'b0;
            abort_addr <= 32'h0000_0000;
            prdata     <= 32'h0000_0000;
        end else begin
            acc_abort <= acc_hit;
            if (acc_hit) begin
                abort_addr <= acc_addr;
            end
            if (apb_setup) begin
                prdata <= next_prdata;
            end else if (!apb_rd) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Level output: it drops only once software has cleared every cause
    // Single line for every cause, held while any cause stays recorded
    assign protection_violation_irq = |violation_cause_monitor;

endmodule

// file: inc/rapu_pkg.sv
package rapu_pkg;

    // Fixed region limits
    localparam logic [31:0] SYS_START     = 32'h0000_0000;
    localparam logic [31:0] R0_START      = 32'h0000_00c8;
    localparam logic [31:0] FLASH_END     = 32'h0002_0000;
    localparam logic [31:0] SRAM_START    = 32'h1000_0000;
    localparam logic [31:0] SRAM_END      = 32'h1000_2000;
    localparam logic [31:0] SFR_START     = 32'h4000_0000;
    localparam logic [31:0] SFR_END       = 32'h5000_0000;
    localparam logic [31:0] PSFR_START    = 32'h4004_0000;
    localparam logic [31:0] PSFR_END      = 32'h4004_0100;
    localparam logic [31:0] PERI_START    = 32'he000_0000;
    localparam logic [31:0] PERI_END      = 32'hf000_0000;

    // Register offsets inside the protection register window
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_R0_END    = 8'h04;
    localparam logic [7:0]  OFS_R1_END    = 8'h08;
    localparam logic [7:0]  OFS_OPTION    = 8'h0c;
    localparam logic [7:0]  OFS_STATUS    = 8'h10;
    localparam logic [7:0]  OFS_MONITOR   = 8'ha0;

    // Reset values
    localparam logic [31:0] R0_END_RST    = 32'h0000_1000;
    localparam logic [31:0] R1_END_RST    = 32'h0000_2000;

    // Field positions
    localparam int          CTRL_EN_BIT   = 0;
    localparam int          OPT_SEL_BIT   = 18;
    localparam int          OPT_DBG_HI    = 17;
    localparam int          OPT_DBG_LO    = 9;
    localparam int          OPT_END_HI    = 8;
    localparam int          OPT_END_LO    = 0;
    localparam int          OPT_SHIFT     = 8;

    // Cause bits of the monitor register
    localparam int          MON_CTRL_WR   = 0;
    localparam int          MON_ADJ_WR    = 1;
    localparam int          MON_DOWN      = 2;
    localparam int          MON_SYS_WR    = 3;
    localparam int          MON_INVALID   = 4;
    localparam int          MON_W         = 5;

    // Target and source classes
    typedef enum logic [3:0] {
        RG_SYS  = 4'b0000,
        RG_R0   = 4'b0001,
        RG_R1   = 4'b0010,
        RG_R2   = 4'b0011,
        RG_R3   = 4'b0100,
        RG_R4   = 4'b0101,
        RG_SFR  = 4'b0110,
        RG_PSFR = 4'b0111,
        RG_PERI = 4'b1000,
        RG_INV  = 4'b1001
    } rapu_region_e;

endpackage

// file: bench/rapu_chk.sv
`timescale 1ns/100ps
module rapu_chk (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        acc_valid,
    input wire logic [31:0] acc_addr,
    input wire logic [31:0] exec_addr,
    input wire logic        acc_abort,
    input wire logic [31:0] abort_addr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    input wire logic        protection_violation_irq
);
    // Shadow of the enable bit, followed from accepted control writes only
    logic en;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            en <= 1'b0;
        end else if (psel && penable && pwrite && !pslverr && paddr == 8'h00) begin
            en <= pwdata[0];
        end
    end

    // Address classes used by the properties
    wire logic exec_sys = exec_addr < 32'h0000_00c8;
    wire logic exec_ram = exec_addr >= 32'h1000_0000 && exec_addr < 32'h1000_2000;
    wire logic tgt_ram  = acc_addr >= 32'h1000_0000 && acc_addr < 32'h1000_2000;
    wire logic tgt_fl   = acc_addr >= 32'h0000_00c8 && acc_addr < 32'h0002_0000;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////
    property p_abort_cause;
        acc_abort |-> $past(acc_valid);
    endproperty
    a_abort_cause: assert property (p_abort_cause) else $error("abort without access");
    property p_abort_addr;
        acc_abort |-> abort_addr == $past(acc_addr);
    endproperty
    a_abort_addr: assert property (p_abort_addr) else $error("abort address wrong");
    property p_irq_shared;
        acc_abort |-> protection_violation_irq;
    endproperty
    a_irq_shared: assert property (p_irq_shared) else $error("abort without irq");
    property p_disabled;
        acc_valid && !en |=> !acc_abort;
    endproperty
    a_disabled: assert property (p_disabled) else $error("abort while disabled");
    property p_invalid;
        acc_valid && en && acc_addr[31:28] == 4'h2 |=> acc_abort;
    endproperty
    a_invalid: assert property (p_invalid) else $error("invalid space not aborted");
    property p_sys_flash;
        acc_valid && en && exec_sys && tgt_fl |=> acc_abort;
    endproperty
    a_sys_flash: assert property (p_sys_flash) else $error("system code reached flash");
    property p_sram_free;
        acc_valid && tgt_ram |=> !acc_abort;
    endproperty
    a_sram_free: assert property (p_sram_free) else $error("SRAM access aborted");
    property p_ctrl_guard;
        psel && penable && pwrite && en && (exec_sys || exec_ram)
            && paddr inside {8'h00, 8'h04, 8'h08} |-> pslverr ##1 protection_violation_irq;
    endproperty
    a_ctrl_guard: assert property (p_ctrl_guard) else $error("control write not refused");
endmodule

bind rapu_top rapu_chk i_rapu_chk (
    .sys_clk                  (sys_clk),
    .rst                      (rst),
    .acc_valid                (acc_valid),
    .acc_addr                 (acc_addr),
    .exec_addr                (exec_addr),
    .acc_abort                (acc_abort),
    .abort_addr               (abort_addr),
    .psel                     (psel),
    .penable                  (penable),
    .pwrite                   (pwrite),
    .paddr                    (paddr),
    .pwdata                   (pwdata),
    .pslverr                  (pslverr),
    .protection_violation_irq (protection_violation_irq)
);

// file: bench/rapu_core.sv
`timescale 1ns/100ps
module rapu_core (
    input  wire logic        sys_clk,
    output logic             acc_valid,
    output logic [31:0]      acc_addr,
    output logic             acc_write,
    output logic [31:0]      exec_addr
);
    initial begin
        acc_valid = 1'b0;
        acc_addr  = 32'h0000_0000;
        acc_write = 1'b0;
        exec_addr = 32'h0000_0000;
    end

    // One access; the code address stays, the released target shows its inverse
    task automatic access(input logic [31:0] from, input logic [31:0] to, input logic wr);
        @(posedge sys_clk);
        acc_valid <= 1'b1;
        acc_addr  <= to;
        acc_write <= wr;
        exec_addr <= from;
        @(posedge sys_clk);
        acc_valid <= 1'b0;
        acc_addr  <= ~to;
        acc_write <= ~wr;
    endtask
endmodule

// file: bench/region_access_protection_unit_test.sv
`timescale 1ns/100ps
module region_access_protection_unit_test;
    logic        sys_clk = 1'b0;
    logic        rst;
    logic [31:0] option_word;
    logic        psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, rd, prdata, abort_addr, acc_addr, exec_addr;
    logic        err, acc_valid, acc_write, acc_abort, pready, pslverr, irq;
    int          n_fail = 0;
    int          n_checks = 0;

    always #2.5 sys_clk = ~sys_clk;

    rapu_core i_rapu_core (.sys_clk(sys_clk), .acc_valid(acc_valid), .acc_addr(acc_addr),
        .acc_write(acc_write), .exec_addr(exec_addr));
    rapu_top i_rapu_top (.sys_clk(sys_clk), .rst(rst), .option_word(option_word),
        .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_write(acc_write),
        .exec_addr(exec_addr), .acc_abort(acc_abort), .abort_addr(abort_addr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .protection_violation_irq(irq));

    ////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // APB transfer; waits on pready as long as it takes, the watchdog catches a hang
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // One core access, then abort, cause, clear and irq release are all checked
    task automatic run_case(input logic [31:0] from, input logic [31:0] to, input logic wr,
                            input logic [4:0] exp);
        i_rapu_core.access(from, to, wr);
        @(posedge sys_clk);
        chk("abort", {31'h0, acc_abort}, {31'h0, |exp});
        chk("irq", {31'h0, irq}, {31'h0, |exp});
        if (|exp) begin
            chk("abort_addr", abort_addr, to);
        end
        apb(1'b0, 8'ha0, 32'h0);
        chk("monitor", rd, {27'h0, exp});
        apb(1'b1, 8'ha0, 32'h0000_001f);
        @(posedge sys_clk);
        chk("irq_clear", {31'h0, irq}, 32'h0);
    endtask

    task automatic do_reset(input logic [31:0] opt);
        option_word <= opt;
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask

    task wrap_up;
        if (n_fail == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        option_word = 32'h0000_8020;
        do_reset(32'h0000_8020);
        apb(1'b0, 8'h04, 32'h0);
        chk("r0_end_rst", rd, 32'h0000_1000);
        apb(1'b0, 8'h08, 32'h0);
        chk("r1_end_rst", rd, 32'h0000_2000);
        apb(1'b0, 8'h14, 32'h0);
        chk("unmapped", {31'h0, err}, 32'h1);
        run_case(32'h2800, 32'h0800, 1'b0, 5'h00);
        apb(1'b0, 8'h10, 32'h0);
        chk("exec_region", rd, 32'h0000_0003);
        apb(1'b0, 8'h0c, 32'h0);
        chk("option", rd, 32'h0000_8020);
        apb(1'b1, 8'h00, 32'h1);
        run_case(32'h0010, 32'h1000_0100, 1'b1, 5'h00);
        apb(1'b1, 8'h00, 32'h0);
        chk("ctrl_refused", {31'h0, err}, 32'h1);
        apb(1'b0, 8'ha0, 32'h0);
        chk("ctrl_cause", rd, 32'h1);
        apb(1'b1, 8'ha0, 32'h0000_001f);
        apb(1'b0, 8'h00, 32'h0);
        chk("ctrl_kept", {31'h0, rd[0]}, 32'h1);
        run_case(32'h1800, 32'h0800, 1'b1, 5'h02);
        run_case(32'h1800, 32'h0800, 1'b0, 5'h00);
        run_case(32'h2800, 32'h0800, 1'b0, 5'h04);
        run_case(32'h0010, 32'h1800, 1'b0, 5'h04);
        run_case(32'h00c4, 32'h00c8, 1'b0, 5'h04);
        run_case(32'h00c8, 32'h00c4, 1'b0, 5'h00);
        run_case(32'h0800, 32'h2800, 1'b1, 5'h00);
        run_case(32'h0800, 32'h2000_0000, 1'b0, 5'h10);
        run_case(32'h2000, 32'h1ffc, 1'b1, 5'h02);
        run_case(32'h1ffc, 32'h1000, 1'b1, 5'h00);
        run_case(32'h1000_1ffc, 32'h2800, 1'b0, 5'h04);
        run_case(32'h0800, 32'h0010, 1'b1, 5'h08);
        apb(1'b1, 8'h04, 32'h0000_1800);
        apb(1'b0, 8'h04, 32'h0);
        chk("r0_end_set", rd, 32'h0000_1800);
        run_case(32'h1400, 32'h0800, 1'b1, 5'h00);
        // Second reset with four flash regions selected
        do_reset(32'h0004_8030);
        apb(1'b1, 8'h00, 32'h1);
        run_case(32'h1000_0100, 32'h3800, 1'b1, 5'h02);
        run_case(32'h1000_0100, 32'h3800, 1'b0, 5'h00);
        run_case(32'h3800, 32'h1800, 1'b0, 5'h04);
        run_case(32'h2800, 32'h3800, 1'b1, 5'h00);
        run_case(32'h3000, 32'h2ffc, 1'b1, 5'h02);
        run_case(32'h1800, 32'h1900, 1'b0, 5'h00);
        apb(1'b1, 8'h08, 32'h0000_2400);
        apb(1'b0, 8'h08, 32'h0);
        chk("r1_end_set", rd, 32'h0000_2400);
        run_case(32'h2200, 32'h1800, 1'b1, 5'h00);
        wrap_up;
    end

    // Watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        wrap_up;
    end
endmodule
